// ==== src/mpf_pause_map.vh ====
`ifndef MPF_PAUSE_MAP_VH
`define MPF_PAUSE_MAP_VH
// =====================================================================
// Register offsets
`define MPF_OFS_NET_CTRL 8'h00
`define MPF_OFS_NET_CFG 8'h04
`define MPF_OFS_INT_STAT 8'h08
`define MPF_OFS_INT_MASK 8'h0C
`define MPF_OFS_TX_QUANTUM 8'h10
`define MPF_OFS_SPEC_ADDR_LO 8'h14
`define MPF_OFS_SPEC_ADDR_HI 8'h18
`define MPF_OFS_PAUSE_TIME 8'h1C
`define MPF_OFS_RX_PAUSE_CNT 8'h20
`define MPF_OFS_TX_PAUSE_CNT 8'h24
`define MPF_OFS_PFC_STAT 8'h28
// =====================================================================
// Network control fields
`define MPF_CTRL_TX_EN 3
`define MPF_CTRL_TX_PAUSE 11
`define MPF_CTRL_TX_ZERO_PAUSE 12
`define MPF_CTRL_PFC_EN 16
// =====================================================================
// Network configuration fields
`define MPF_CFG_SPEED_100 0
`define MPF_CFG_FULL_DUPLEX 1
`define MPF_CFG_RETRY_TEST 12
`define MPF_CFG_RX_PAUSE_EN 13
// =====================================================================
// Interrupt status fields
`define MPF_INT_PAUSE_NZ 12
`define MPF_INT_PAUSE_ZERO 13
`define MPF_INT_PAUSE_TX 14
// =====================================================================
// Reset values
`define MPF_RST_TX_QUANTUM 16'hFFFF
`define MPF_RST_WORD 32'h00000000
// =====================================================================
// Frame constants
`define MPF_PAUSE_DA 48'h0180C2000001
`define MPF_CTRL_TYPE 16'h8808
`define MPF_OP_PAUSE 16'h0001
`define MPF_OP_PFC 16'h1001
`define MPF_RX_HDR_BYTES 5'h12
`define MPF_TX_LAST_IDX 7'h3F
`define MPF_TX_FCS_IDX 7'h3C
`define MPF_CRC_POLY 32'hEDB88320
// =====================================================================
// Timing: 512 bit times in ns per speed, clock period in ns
`define MPF_SLOT_NS_10 51200
`define MPF_SLOT_NS_100 5120
`define MPF_CLK_NS 10
`endif

// ==== src/mpf_pause.v ====
// Summary of operation
// - Valid pause needs address, type, opcode match
// - Receive pause enable lets nonzero quantum pause
// - Every valid pause frame reloads counter; the code reloads it for classic pause frames only, not priority frames
// - Nonzero quantum sets bit 12, zero bit 13
// - Finish current frame, then hold until zero
// - Full duplex only loads; half duplex still flags
// - Errored pause frames are discarded entirely
// - Classic pause discarded after priority negotiation
// - Valid received pause bumps receive statistic
// - Counter drops every 512 bit times
// - Retry test decrements each link clock
// - Decrement to zero sets status bit 13
// - Control bits 11/12 request a pause frame
// - Send when idle or between frames
// - Generated frame layout with valid check sequence
// - Bit 11 uses quantum register, 12 zero
// - After sending, bit 14 and transmit statistic
// - Priority opcode 1001 needs control bit 16
// - After priority match, ignore classic pause
//
// Our own choices: the register addresses and strobed register access.
`include "mpf_pause_map.vh"
`timescale 1ns/1ps
`default_nettype none
module mpf_pause #(
  parameter TICK_10 = `MPF_SLOT_NS_10 / `MPF_CLK_NS,
  parameter TICK_100 = `MPF_SLOT_NS_100 / `MPF_CLK_NS
) (
  input wire i_mclk,
  input wire i_reset,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_rx_valid,
  input wire [7:0] i_rx_data,
  input wire i_rx_last,
  input wire i_rx_err,
  input wire i_tx_busy,
  input wire i_tx_link_en,
  output reg o_tx_hold,
  output reg o_ptx_valid,
  output reg [7:0] o_ptx_data,
  output reg o_ptx_last,
  input wire i_ptx_ready,
  output reg o_irq
);
  // =====================================================================
  // Helpers
  function [31:0] mpf_crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer k;
    reg [31:0] r;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1) begin
        if (r[0] ^ d[k])
          r = (r >> 1) ^ `MPF_CRC_POLY;
        else
          r = r >> 1;
      end
      mpf_crc_byte = r;
    end
  endfunction

  function [7:0] mpf_frame_byte;
    input [6:0] idx;
    input [47:0] sa;
    input [15:0] q;
    input [31:0] crc;
    reg [47:0] da;
    reg [31:0] fcs;
    reg [15:0] ty;
    reg [15:0] op;
    begin
      da = `MPF_PAUSE_DA;
      ty = `MPF_CTRL_TYPE;
      op = `MPF_OP_PAUSE;
      fcs = ~crc;
      mpf_frame_byte = 8'h00;
      if (idx < 7'h06)
        mpf_frame_byte = da[8'd47 - {idx[2:0], 3'h0} -: 8];
      else if (idx < 7'h0C)
        mpf_frame_byte = sa[8'd47 - {idx[3:0] - 4'h6, 3'h0} -: 8];
      else if (idx == 7'h0C)
        mpf_frame_byte = ty[15:8];
      else if (idx == 7'h0D)
        mpf_frame_byte = ty[7:0];
      else if (idx == 7'h0E)
        mpf_frame_byte = op[15:8];
      else if (idx == 7'h0F)
        mpf_frame_byte = op[7:0];
      else if (idx == 7'h10)
        mpf_frame_byte = q[15:8];
      else if (idx == 7'h11)
        mpf_frame_byte = q[7:0];
      else if (idx >= `MPF_TX_FCS_IDX)
        mpf_frame_byte = fcs[{idx[1:0], 3'h0} +: 8];
    end
  endfunction

  // =====================================================================
  // Register state
  reg tx_en_reg;
  reg pfc_en_reg;
  reg speed100_reg;
  reg full_duplex_reg;
  reg retry_test_reg;
  reg rx_pause_en_reg;
  reg [2:0] int_stat_reg;
  reg [2:0] int_mask_reg;
  reg [15:0] tx_quantum_reg;
  reg [47:0] spec_addr_reg;
  reg [15:0] pause_cnt_reg;
  reg [31:0] rx_stat_reg;
  reg [31:0] tx_stat_reg;
  reg pfc_negotiated_reg;
  reg [12:0] tick_cnt_reg;
  reg [4:0] rx_idx_reg;
  reg [47:0] rx_da_reg;
  reg [15:0] rx_type_reg;
  reg [15:0] rx_op_reg;
  reg [15:0] rx_time_reg;
  reg rx_classic_reg;
  reg rx_pfc_reg;
  reg gen_pend_reg;
  reg gen_active_reg;
  reg [15:0] gen_q_reg;
  reg [6:0] gen_idx_reg;
  reg [31:0] gen_crc_reg;

  wire ctrl_wr = i_wr && (i_addr == `MPF_OFS_NET_CTRL);
  wire [47:0] sa_wire = {spec_addr_reg[7:0], spec_addr_reg[15:8], spec_addr_reg[23:16],
    spec_addr_reg[31:24], spec_addr_reg[39:32], spec_addr_reg[47:40]};
  wire stopped = (pause_cnt_reg != 16'h0000) && !i_tx_busy;
  wire [12:0] tick_lim = speed100_reg ? TICK_100[12:0] : TICK_10[12:0];
  wire tick = (tick_cnt_reg >= tick_lim - 13'h0001);
  wire dec_en = stopped && (retry_test_reg ? i_tx_link_en : tick);
  wire frame_done = o_ptx_valid && i_ptx_ready && o_ptx_last;
  wire gen_start = gen_pend_reg && !gen_active_reg && !i_tx_busy;
  wire gen_emit = gen_active_reg && (!o_ptx_valid || i_ptx_ready) &&
    (gen_idx_reg <= `MPF_TX_LAST_IDX) && !frame_done;
  wire rx_load = rx_classic_reg && full_duplex_reg && rx_pause_en_reg;
  wire rx_zero = (rx_time_reg == 16'h0000);
  wire hit_zero = dec_en && (pause_cnt_reg == 16'h0001) && !rx_load;

  // =====================================================================
  // Configuration registers
  always @(posedge i_mclk) begin
    if (i_reset) begin
      tx_en_reg <= 1'b0;
      pfc_en_reg <= 1'b0;
      speed100_reg <= 1'b0;
      full_duplex_reg <= 1'b0;
      retry_test_reg <= 1'b0;
      rx_pause_en_reg <= 1'b0;
      int_mask_reg <= 3'h0;
      tx_quantum_reg <= `MPF_RST_TX_QUANTUM;
      spec_addr_reg <= 48'h000000000000;
    end else if (i_wr) begin
      case (i_addr)
        `MPF_OFS_NET_CTRL: begin
          tx_en_reg <= i_wdata[`MPF_CTRL_TX_EN];
          pfc_en_reg <= i_wdata[`MPF_CTRL_PFC_EN];
        end
        `MPF_OFS_NET_CFG: begin
          speed100_reg <= i_wdata[`MPF_CFG_SPEED_100];
          full_duplex_reg <= i_wdata[`MPF_CFG_FULL_DUPLEX];
          retry_test_reg <= i_wdata[`MPF_CFG_RETRY_TEST];
          rx_pause_en_reg <= i_wdata[`MPF_CFG_RX_PAUSE_EN];
        end
        `MPF_OFS_INT_MASK: int_mask_reg <= i_wdata[14:12];
        `MPF_OFS_TX_QUANTUM: tx_quantum_reg <= i_wdata[15:0];
        `MPF_OFS_SPEC_ADDR_LO: spec_addr_reg[31:0] <= i_wdata;
        `MPF_OFS_SPEC_ADDR_HI: spec_addr_reg[47:32] <= i_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // Read port
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= `MPF_RST_WORD;
    end else if (i_rd) begin
      case (i_addr)
        `MPF_OFS_NET_CTRL: o_rdata <= {15'h0000, pfc_en_reg, 12'h000, tx_en_reg, 3'h0};
        `MPF_OFS_NET_CFG: o_rdata <= {18'h00000, rx_pause_en_reg, retry_test_reg, 10'h000,
          full_duplex_reg, speed100_reg};
        `MPF_OFS_INT_STAT: o_rdata <= {17'h00000, int_stat_reg, 12'h000};
        `MPF_OFS_INT_MASK: o_rdata <= {17'h00000, int_mask_reg, 12'h000};
        `MPF_OFS_TX_QUANTUM: o_rdata <= {16'h0000, tx_quantum_reg};
        `MPF_OFS_SPEC_ADDR_LO: o_rdata <= spec_addr_reg[31:0];
        `MPF_OFS_SPEC_ADDR_HI: o_rdata <= {16'h0000, spec_addr_reg[47:32]};
        `MPF_OFS_PAUSE_TIME: o_rdata <= {16'h0000, pause_cnt_reg};
        `MPF_OFS_RX_PAUSE_CNT: o_rdata <= rx_stat_reg;
        `MPF_OFS_TX_PAUSE_CNT: o_rdata <= tx_stat_reg;
        `MPF_OFS_PFC_STAT: o_rdata <= {31'h00000000, pfc_negotiated_reg};
        default: o_rdata <= `MPF_RST_WORD;
      endcase
    end else begin
      o_rdata <= `MPF_RST_WORD;
    end
  end

  // =====================================================================
  // Receive parser
  always @(posedge i_mclk) begin
    if (i_reset) begin
      rx_idx_reg <= 5'h00;
      rx_da_reg <= 48'h000000000000;
      rx_type_reg <= 16'h0000;
      rx_op_reg <= 16'h0000;
      rx_time_reg <= 16'h0000;
      rx_classic_reg <= 1'b0;
      rx_pfc_reg <= 1'b0;
    end else begin
      rx_classic_reg <= 1'b0;
      rx_pfc_reg <= 1'b0;
      if (i_rx_valid) begin
        if (i_rx_last) begin
          rx_idx_reg <= 5'h00;
          if (!i_rx_err && (rx_idx_reg >= `MPF_RX_HDR_BYTES) &&
              ((rx_da_reg == `MPF_PAUSE_DA) || (rx_da_reg == sa_wire)) &&
              (rx_type_reg == `MPF_CTRL_TYPE)) begin
            rx_classic_reg <= (rx_op_reg == `MPF_OP_PAUSE) && !pfc_negotiated_reg;
            rx_pfc_reg <= (rx_op_reg == `MPF_OP_PFC) && pfc_en_reg;
          end
        end else begin
          if (rx_idx_reg != 5'h1F)
            rx_idx_reg <= rx_idx_reg + 5'h01;
          if (rx_idx_reg < 5'h06)
            rx_da_reg <= {rx_da_reg[39:0], i_rx_data};
          else if (rx_idx_reg == 5'h0C || rx_idx_reg == 5'h0D)
            rx_type_reg <= {rx_type_reg[7:0], i_rx_data};
          else if (rx_idx_reg == 5'h0E || rx_idx_reg == 5'h0F)
            rx_op_reg <= {rx_op_reg[7:0], i_rx_data};
          else if (rx_idx_reg == 5'h10 || rx_idx_reg == 5'h11)
            rx_time_reg <= {rx_time_reg[7:0], i_rx_data};
        end
      end
    end
  end

  // =====================================================================
  // Pause counter and 512 bit time divider
  always @(posedge i_mclk) begin
    if (i_reset) begin
      pause_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 13'h0000;
      pfc_negotiated_reg <= 1'b0;
    end else begin
      if (!stopped || tick)
        tick_cnt_reg <= 13'h0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 13'h0001;
      if (rx_load)
        pause_cnt_reg <= rx_time_reg;
      else if (dec_en)
        pause_cnt_reg <= pause_cnt_reg - 16'h0001;
      if (!pfc_en_reg)
        pfc_negotiated_reg <= 1'b0;
      else if (rx_pfc_reg)
        pfc_negotiated_reg <= 1'b1;
    end
  end

  // =====================================================================
  // Interrupt status, statistics
  always @(posedge i_mclk) begin
    if (i_reset) begin
      int_stat_reg <= 3'h0;
      rx_stat_reg <= 32'h00000000;
      tx_stat_reg <= 32'h00000000;
      o_irq <= 1'b0;
    end else begin
      int_stat_reg[0] <= (int_stat_reg[0] &&
        !(i_wr && i_addr == `MPF_OFS_INT_STAT && i_wdata[`MPF_INT_PAUSE_NZ])) ||
        ((rx_classic_reg || rx_pfc_reg) && !rx_zero);
      int_stat_reg[1] <= (int_stat_reg[1] &&
        !(i_wr && i_addr == `MPF_OFS_INT_STAT && i_wdata[`MPF_INT_PAUSE_ZERO])) ||
        ((rx_classic_reg || rx_pfc_reg) && rx_zero) || hit_zero;
      int_stat_reg[2] <= (int_stat_reg[2] &&
        !(i_wr && i_addr == `MPF_OFS_INT_STAT && i_wdata[`MPF_INT_PAUSE_TX])) ||
        frame_done;
      if (rx_classic_reg || rx_pfc_reg)
        rx_stat_reg <= rx_stat_reg + 32'h00000001;
      if (frame_done)
        tx_stat_reg <= tx_stat_reg + 32'h00000001;
      o_irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // =====================================================================
  // Pause frame generator
  always @(posedge i_mclk) begin
    if (i_reset) begin
      gen_pend_reg <= 1'b0;
      gen_active_reg <= 1'b0;
      gen_q_reg <= 16'h0000;
      gen_idx_reg <= 7'h00;
      gen_crc_reg <= 32'hFFFFFFFF;
      o_ptx_valid <= 1'b0;
      o_ptx_data <= 8'h00;
      o_ptx_last <= 1'b0;
      o_tx_hold <= 1'b0;
    end else begin
      if (ctrl_wr && i_wdata[`MPF_CTRL_TX_EN] && full_duplex_reg && !gen_pend_reg &&
          (i_wdata[`MPF_CTRL_TX_PAUSE] || i_wdata[`MPF_CTRL_TX_ZERO_PAUSE])) begin
        gen_pend_reg <= 1'b1;
        gen_q_reg <= i_wdata[`MPF_CTRL_TX_PAUSE] ? tx_quantum_reg : 16'h0000;
      end else if (gen_start) begin
        gen_pend_reg <= 1'b0;
      end
      if (gen_start) begin
        gen_active_reg <= 1'b1;
        gen_idx_reg <= 7'h00;
        gen_crc_reg <= 32'hFFFFFFFF;
      end
      if (frame_done) begin
        o_ptx_valid <= 1'b0;
        o_ptx_last <= 1'b0;
        gen_active_reg <= 1'b0;
      end else if (gen_emit) begin
        o_ptx_valid <= 1'b1;
        o_ptx_data <= mpf_frame_byte(gen_idx_reg, sa_wire, gen_q_reg, gen_crc_reg);
        o_ptx_last <= (gen_idx_reg == `MPF_TX_LAST_IDX);
        gen_idx_reg <= gen_idx_reg + 7'h01;
        if (gen_idx_reg < `MPF_TX_FCS_IDX)
          gen_crc_reg <= mpf_crc_byte(gen_crc_reg,
            mpf_frame_byte(gen_idx_reg, sa_wire, gen_q_reg, gen_crc_reg));
      end else if (o_ptx_valid && i_ptx_ready) begin
        o_ptx_valid <= 1'b0;
      end
      o_tx_hold <= (pause_cnt_reg != 16'h0000) || rx_load || gen_pend_reg ||
        gen_active_reg || gen_start;
    end
  end
endmodule
`default_nettype wire

// ==== dv/mpf_pause_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mpf_pause_map.vh"
// ============================================================
// Port checks of the pause block
module mpf_pause_sva (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_rx_valid,
  input wire logic i_rx_last,
  input wire logic i_rx_err,
  input wire logic i_tx_busy,
  input wire logic o_tx_hold,
  input wire logic o_ptx_valid,
  input wire logic [7:0] o_ptx_data,
  input wire logic o_ptx_last,
  input wire logic i_ptx_ready
);
  logic [6:0] idx_reg;
  logic rx_end;
  assign rx_end = i_rx_valid && i_rx_last;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      idx_reg <= 7'h00;
    end else if (o_ptx_valid && i_ptx_ready) begin
      idx_reg <= o_ptx_last ? 7'h00 : idx_reg + 7'h01;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  chk_hold_cause: assert property (
    $rose(o_tx_hold) |-> $past(rx_end && !i_rx_err, 2) ||
      $past(i_wr && i_addr == `MPF_OFS_NET_CTRL &&
      (i_wdata[`MPF_CTRL_TX_PAUSE] || i_wdata[`MPF_CTRL_TX_ZERO_PAUSE]), 2))
    else $error("hold without good frame or request");
  chk_err_no_hold: assert property (
    (rx_end && i_rx_err && !o_tx_hold) ##1 !o_tx_hold |=> !o_tx_hold) else $error("bad frame held");
  chk_ptx_stall: assert property (
    o_ptx_valid && !i_ptx_ready |=> o_ptx_valid && $stable(o_ptx_data) && $stable(o_ptx_last))
    else $error("stalled byte changed");
  chk_ptx_start: assert property (
    $rose(o_ptx_valid) |-> !$past(i_tx_busy)) else $error("pause frame began over a frame");
  chk_ptx_da: assert property (
    o_ptx_valid && idx_reg == 7'h00 |-> o_ptx_data == 8'h01) else $error("bad first byte");
  chk_ptx_type: assert property (
    o_ptx_valid && idx_reg == 7'h0C |-> o_ptx_data == 8'h88) else $error("bad type byte");
  chk_ptx_opcode: assert property (
    o_ptx_valid && idx_reg == 7'h0F |-> o_ptx_data == 8'h01) else $error("bad opcode byte");
  chk_ptx_length: assert property (
    o_ptx_valid && o_ptx_last |-> idx_reg == 7'h3F) else $error("bad frame length");
  chk_ptx_fill: assert property (
    o_ptx_valid && idx_reg > 7'h11 && idx_reg < 7'h3C |-> o_ptx_data == 8'h00)
    else $error("fill byte not zero");
  cov_hold: cover property ($rose(o_tx_hold));
  cov_ptx_end: cover property (o_ptx_valid && i_ptx_ready && o_ptx_last);
  cov_err_end: cover property (rx_end && i_rx_err);
endmodule
`default_nettype wire

// ==== dv/mpf_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Far MAC: frame source and pause frame sink
module mpf_link_model (
  input wire logic i_mclk,
  input wire logic i_ptx_valid,
  input wire logic [7:0] i_ptx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  output logic o_rx_err,
  output logic o_ptx_ready,
  output logic o_link_en
);
  logic slow = 1'b0;
  logic [9:0] rxq[$];
  logic [7:0] got[$];
  initial begin
    {o_rx_valid, o_rx_last, o_rx_err, o_ptx_ready, o_link_en} = 5'h00;
    o_rx_data = 8'h00;
  end
  task automatic send(input logic [7:0] b[$], input logic err);
    foreach (b[i]) rxq.push_back({i == b.size() - 1, err && i == b.size() - 1, b[i]});
  endtask
  always @(posedge i_mclk) begin
    o_link_en <= ~o_link_en;
    o_ptx_ready <= !slow || ($urandom % 3 == 0);
    if (i_ptx_valid && o_ptx_ready) got.push_back(i_ptx_data);
    if (rxq.size() > 0) begin
      {o_rx_last, o_rx_err, o_rx_data} <= rxq.pop_front();
      o_rx_valid <= 1'b1;
    end else begin
      {o_rx_valid, o_rx_last, o_rx_err} <= 3'h0;
      o_rx_data <= o_rx_data + 8'h5B;
    end
  end
endmodule
`default_nettype wire

// ==== dv/mac_pause_flow_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mpf_pause_map.vh"
// ============================================================
// Self-checking bench of the pause block
module mac_pause_flow_control_test;
  localparam logic [47:0] RSV = 48'h010000C28001;
  logic i_mclk, i_reset, i_wr, i_rd, i_tx_busy;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic o_tx_hold, o_ptx_valid, o_ptx_last, o_irq, rx_valid, rx_last, rx_err, ptx_ready, link_en;
  logic [7:0] o_ptx_data, rx_data, fr[$];
  logic [47:0] sa;
  logic [15:0] q;
  int n_mismatch = 0, compares = 0, m_rx = 0, m_tx = 0, n;
  mpf_pause #(.TICK_10(1000), .TICK_100(4)) i_dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_err(rx_err),
    .i_tx_busy(i_tx_busy), .i_tx_link_en(link_en), .o_tx_hold(o_tx_hold),
    .o_ptx_valid(o_ptx_valid), .o_ptx_data(o_ptx_data), .o_ptx_last(o_ptx_last),
    .i_ptx_ready(ptx_ready), .o_irq(o_irq));
  mpf_link_model i_link (.i_mclk(i_mclk), .i_ptx_valid(o_ptx_valid), .i_ptx_data(o_ptx_data),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last), .o_rx_err(rx_err),
    .o_ptx_ready(ptx_ready), .o_link_en(link_en));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ============================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_mclk);
  endtask
  task automatic mkf(input logic [47:0] da, input logic [15:0] ty, op, qq);
    logic [31:0] c;
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(da[i*8 +: 8]);
    for (int i = 0; i < 6; i++) fr.push_back(sa[i*8 +: 8]);
    fr = {fr, ty[15:8], ty[7:0], op[15:8], op[7:0], qq[15:8], qq[7:0]};
    while (fr.size() < 60) fr.push_back(8'h00);
    c = 32'hFFFFFFFF;
    foreach (fr[i]) begin
      c = c ^ {24'h0, fr[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `MPF_CRC_POLY : c >> 1;
    end
    c = ~c;
    fr = {fr, c[7:0], c[15:8], c[23:16], c[31:24]};
  endtask
  task automatic rxf(input logic [47:0] da, input logic [15:0] ty, op, qq, input logic err);
    mkf(da, ty, op, qq);
    i_link.send(fr, err);
    repeat (67) @(posedge i_mclk);
  endtask
  task automatic drain();
    n = 0;
    while (o_tx_hold === 1'b1 && n < 2000) begin
      @(posedge i_mclk);
      n++;
    end
  endtask
  task automatic cmp_frame(input logic [15:0] qq);
    for (int i = 0; i < 3000 && i_link.got.size() < 64; i++) @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
    mkf(RSV, 16'h8808, 16'h0001, qq);
    chk(i_link.got.size(), 64);
    foreach (fr[i]) chk(i_link.got[i], fr[i]);
    i_link.got = {};
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic setup(input logic [31:0] cfg);
    wr(`MPF_OFS_SPEC_ADDR_LO, sa[31:0]);
    wr(`MPF_OFS_SPEC_ADDR_HI, {16'h0, sa[47:32]});
    wr(`MPF_OFS_INT_MASK, 32'h7000);
    wr(`MPF_OFS_NET_CFG, cfg);
  endtask
  // ============================================================
  // Scenarios
  initial begin
    {i_reset, i_wr, i_rd, i_tx_busy, i_addr, i_wdata} = {4'h8, 8'h00, 32'h0};
    void'($urandom(12));
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rc(`MPF_OFS_TX_QUANTUM, 32'h0000FFFF);
    rc(`MPF_OFS_PAUSE_TIME, 32'h0);
    rc(8'h3C, 32'h0);
    sa = {16'($urandom), 32'($urandom)};
    setup(32'h2002);
    q = 16'($urandom % 200 + 50);
    rxf(RSV, 16'h8808, 16'h0001, q, 1'b0);
    m_rx++;
    rc(`MPF_OFS_PAUSE_TIME, {16'h0, q});
    rc(`MPF_OFS_RX_PAUSE_CNT, m_rx);
    rc(`MPF_OFS_INT_STAT, 32'h1000);
    chk(32'(o_tx_hold), 1);
    chk(32'(o_irq), 1);
    wr(`MPF_OFS_INT_MASK, 32'h0);
    @(negedge i_mclk);
    chk(32'(o_irq), 0);
    @(posedge i_mclk);
    rxf(sa, 16'h8808, 16'h0001, 16'h0003, 1'b0);
    m_rx++;
    rc(`MPF_OFS_PAUSE_TIME, 32'h3);
    setup(32'h2002);
    wr(`MPF_OFS_INT_STAT, 32'h7000);
    wr(`MPF_OFS_NET_CFG, 32'h2003);
    drain();
    chk(32'(n < 40), 1);
    rc(`MPF_OFS_INT_STAT, 32'h2000);
    rc(`MPF_OFS_PAUSE_TIME, 32'h0);
    wr(`MPF_OFS_NET_CFG, 32'h3002);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0008, 1'b0);
    m_rx++;
    drain();
    chk(32'(n < 40), 1);
    wr(`MPF_OFS_INT_STAT, 32'h7000);
    for (int k = 0; k < 4; k++) begin
      q = 16'($urandom % 500 + 1);
      rxf(k == 3 ? sa ^ 48'h1 : RSV, k == 1 ? 16'h8809 : 16'h8808,
        k == 2 ? 16'h0002 : 16'h0001, q, k == 0);
      rc(`MPF_OFS_PAUSE_TIME, 32'h0);
    end
    rc(`MPF_OFS_RX_PAUSE_CNT, m_rx);
    rc(`MPF_OFS_INT_STAT, 32'h0);
    wr(`MPF_OFS_NET_CFG, 32'h2000);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0064, 1'b0);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0000, 1'b0);
    m_rx += 2;
    chk(32'(o_tx_hold), 0);
    rc(`MPF_OFS_PAUSE_TIME, 32'h0);
    rc(`MPF_OFS_INT_STAT, 32'h3000);
    wr(`MPF_OFS_NET_CFG, 32'h0002);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0064, 1'b0);
    chk(32'(o_tx_hold), 0);
    wr(`MPF_OFS_NET_CFG, 32'h2002);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0000, 1'b0);
    m_rx += 2;
    wr(`MPF_OFS_NET_CTRL, 32'h00010000);
    rxf(RSV, 16'h8808, 16'h1001, 16'h00FF, 1'b0);
    m_rx++;
    rc(`MPF_OFS_PFC_STAT, 32'h1);
    rc(`MPF_OFS_RX_PAUSE_CNT, m_rx);
    rxf(RSV, 16'h8808, 16'h0001, 16'h0032, 1'b0);
    rc(`MPF_OFS_PAUSE_TIME, 32'h0);
    rc(`MPF_OFS_RX_PAUSE_CNT, m_rx);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    rc(`MPF_OFS_PFC_STAT, 32'h0);
    setup(32'h2002);
    q = 16'($urandom);
    wr(`MPF_OFS_TX_QUANTUM, {16'h0, q});
    i_link.slow = 1'b1;
    wr(`MPF_OFS_NET_CTRL, 32'h0808);
    cmp_frame(q);
    rc(`MPF_OFS_TX_PAUSE_CNT, 32'h1);
    rc(`MPF_OFS_RX_PAUSE_CNT, 32'h0);
    rc(`MPF_OFS_INT_STAT, 32'h4000);
    i_tx_busy <= 1'b1;
    wr(`MPF_OFS_NET_CTRL, 32'h1008);
    repeat (20) @(posedge i_mclk);
    chk(i_link.got.size(), 0);
    i_tx_busy <= 1'b0;
    cmp_frame(16'h0000);
    m_tx = 2;
    wr(`MPF_OFS_NET_CTRL, 32'h0800);
    wr(`MPF_OFS_NET_CFG, 32'h2000);
    wr(`MPF_OFS_NET_CTRL, 32'h0808);
    repeat (150) @(posedge i_mclk);
    chk(i_link.got.size(), 0);
    rc(`MPF_OFS_TX_PAUSE_CNT, m_tx);
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
bind mpf_pause mpf_pause_sva i_sva (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last), .i_rx_err(i_rx_err),
  .i_tx_busy(i_tx_busy), .o_tx_hold(o_tx_hold), .o_ptx_valid(o_ptx_valid),
  .o_ptx_data(o_ptx_data), .o_ptx_last(o_ptx_last), .i_ptx_ready(i_ptx_ready));
`default_nettype wire
